// File: src/iur_pkg.sv
// Constants, register map and field layout of the infrared UART port
package iur_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] IUR_RX_TX_CHAR_PORT_ADDR = 32'hff201020;
  localparam logic [31:0] IUR_IRQ_SETTINGS_ADDR = 32'hff201024;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int IUR_DATA_LSB = 0;
  localparam int IUR_DATA_MSB = 7;
  localparam int IUR_VALID_BIT = 15;
  localparam int IUR_FILL_LSB = 16;
  localparam int IUR_FILL_MSB = 23;
  localparam int IUR_RE_BIT = 0;
  localparam int IUR_RI_BIT = 8;
  // ------------------------------------------------------------
  // Framing and timing
  // ------------------------------------------------------------
  localparam int IUR_DATA_BITS = 8;
  localparam int IUR_FIFO_DEPTH = 128;
  localparam int IUR_CLK_HZ = 200000000;
  localparam int IUR_BAUD = 155200;
  localparam int IUR_BIT_CYCLES = IUR_CLK_HZ / IUR_BAUD;
  localparam int IUR_CNT_W = 16;
  localparam logic [IUR_CNT_W-1:0] IUR_CNT_ZERO = 16'h0000;
  localparam logic [31:0] IUR_WORD_ZERO = 32'h00000000;
  typedef enum logic [1:0] {IUR_IDLE, IUR_START, IUR_DATA, IUR_STOP} iur_state_t;
endpackage

// File: src/iur_rx_fifo.sv
// Receive character FIFO with occupancy count
`timescale 1ns/1ps
module iur_rx_fifo
#(
  parameter int DEPTH = iur_pkg::IUR_FIFO_DEPTH,
  parameter int WIDTH = iur_pkg::IUR_DATA_BITS
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic [$clog2(DEPTH):0] o_count
);
  import iur_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_CNT = 1;
  localparam logic [AW-1:0] ONE_PTR = 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic do_push;
  logic do_pop;

  // Drop pushes when full, ignore pops when empty
  assign do_push = i_push && (o_count != FULL_CNT);
  assign do_pop = i_pop && (o_count != '0);
  assign o_head = mem[rd_ptr_reg];

  // Storage write
  always_ff @(posedge i_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      o_count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= wr_ptr_reg + ONE_PTR;
      end
      if (do_pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + ONE_PTR;
      end
      if (do_push && !do_pop)
      begin
        o_count <= o_count + ONE_CNT;
      end
      else if (do_pop && !do_push)
      begin
        o_count <= o_count - ONE_CNT;
      end
    end
  end
endmodule

// File: src/iur_tx.sv
// Serial transmitter for one character frame
`timescale 1ns/1ps
module iur_tx
#(
  parameter int BIT_CYCLES = iur_pkg::IUR_BIT_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [iur_pkg::IUR_DATA_BITS-1:0] i_data,
  output logic o_busy,
  output logic o_txd
);
  import iur_pkg::*;
  localparam logic [IUR_CNT_W-1:0] LAST_CNT = IUR_CNT_W'(BIT_CYCLES - 1);
  localparam logic [2:0] LAST_BIT = 3'(IUR_DATA_BITS - 1);
  iur_state_t state_reg;
  logic [IUR_CNT_W-1:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [IUR_DATA_BITS-1:0] shift_reg;
  logic tick;

  assign tick = (cnt_reg == LAST_CNT);
  assign o_busy = (state_reg != IUR_IDLE);

  // Frame sequencer: start, eight data bits LSB first, one stop, no parity
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= IUR_IDLE;
      cnt_reg <= IUR_CNT_ZERO;
      bit_reg <= '0;
      shift_reg <= '0;
      o_txd <= 1'b1;
    end
    else
    begin
      cnt_reg <= (tick || state_reg == IUR_IDLE) ? IUR_CNT_ZERO : cnt_reg + 16'h0001;
      case (state_reg)
        IUR_IDLE:
        begin
          o_txd <= 1'b1;
          if (i_start)
          begin
            shift_reg <= i_data;
            o_txd <= 1'b0;
            state_reg <= IUR_START;
          end
        end
        IUR_START:
        begin
          if (tick)
          begin
            o_txd <= shift_reg[0];
            bit_reg <= '0;
            state_reg <= IUR_DATA;
          end
        end
        IUR_DATA:
        begin
          if (tick)
          begin
            if (bit_reg == LAST_BIT)
            begin
              o_txd <= 1'b1;
              state_reg <= IUR_STOP;
            end
            else
            begin
              o_txd <= shift_reg[1];
              shift_reg <= shift_reg >> 1;
              bit_reg <= bit_reg + 3'h1;
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            state_reg <= IUR_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// File: src/iur_top.sv
// Infrared UART port: receiver, register file and transmitter
`timescale 1ns/1ps
module iur_top
#(
  parameter int BIT_CYCLES = iur_pkg::IUR_BIT_CYCLES,
  parameter int DEPTH = iur_pkg::IUR_FIFO_DEPTH
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_addr,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_txd,
  input wire logic i_rxd
);
  import iur_pkg::*;
  localparam logic [IUR_CNT_W-1:0] LAST_CNT = IUR_CNT_W'(BIT_CYCLES - 1);
  localparam logic [IUR_CNT_W-1:0] HALF_CNT = IUR_CNT_W'(BIT_CYCLES / 2);
  localparam logic [2:0] LAST_BIT = 3'(IUR_DATA_BITS - 1);
  localparam int CW = $clog2(DEPTH) + 1;

  // ------------------------------------------------------------
  // Receive pin synchroniser
  // ------------------------------------------------------------
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= i_rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  iur_state_t rx_state_reg;
  logic [IUR_CNT_W-1:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [IUR_DATA_BITS-1:0] rx_shift_reg;
  logic rx_push_reg;
  logic rx_tick;
  logic rx_half;
  assign rx_tick = (rx_cnt_reg == LAST_CNT);
  assign rx_half = (rx_cnt_reg == HALF_CNT);

  // Frame sequencer: start detect, mid start re-check, data bits, stop
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_state_reg <= IUR_IDLE;
    end
    else
    begin
      case (rx_state_reg)
        IUR_IDLE:
        begin
          if (!rxd_sync_reg)
          begin
            rx_state_reg <= IUR_START;
          end
        end
        IUR_START:
        begin
          // Re-check line at mid start bit to reject glitches
          if (rx_half)
          begin
            rx_state_reg <= rxd_sync_reg ? IUR_IDLE : IUR_DATA;
          end
        end
        IUR_DATA:
        begin
          if (rx_tick && (rx_bit_reg == LAST_BIT))
          begin
            rx_state_reg <= IUR_STOP;
          end
        end
        default:
        begin
          if (rx_tick)
          begin
            rx_state_reg <= IUR_IDLE;
          end
        end
      endcase
    end
  end

  // Bit timer: held at zero while idle, restarted at mid start bit and at each bit centre sample
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_cnt_reg <= IUR_CNT_ZERO;
    end
    else if ((rx_state_reg == IUR_IDLE) || rx_tick)
    begin
      rx_cnt_reg <= IUR_CNT_ZERO;
    end
    else if ((rx_state_reg == IUR_START) && rx_half)
    begin
      rx_cnt_reg <= IUR_CNT_ZERO;
    end
    else
    begin
      rx_cnt_reg <= rx_cnt_reg + 16'h0001;
    end
  end

  // Data bit counter, cleared when the start bit is confirmed
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_bit_reg <= '0;
    end
    else if ((rx_state_reg == IUR_START) && rx_half)
    begin
      rx_bit_reg <= '0;
    end
    else if ((rx_state_reg == IUR_DATA) && rx_tick && (rx_bit_reg != LAST_BIT))
    begin
      rx_bit_reg <= rx_bit_reg + 3'h1;
    end
  end

  // Data shifter, LSB first, one sample per bit centre; no parity slot
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_shift_reg <= '0;
    end
    else if ((rx_state_reg == IUR_DATA) && rx_tick)
    begin
      rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[IUR_DATA_BITS-1:1]};
    end
  end

  // Push strobe at mid stop bit; a low stop bit is a framing error and drops the character
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_push_reg <= 1'b0;
    end
    else
    begin
      rx_push_reg <= (rx_state_reg == IUR_STOP) && rx_tick && rxd_sync_reg;
    end
  end

  // ------------------------------------------------------------
  // Receive FIFO
  // ------------------------------------------------------------
  logic [IUR_DATA_BITS-1:0] fifo_head;
  logic [CW-1:0] fifo_count;
  logic rd_data;
  logic wr_data;
  logic rd_ctrl;
  logic wr_ctrl;
  logic fifo_pop;

  // Address decode
  assign rd_data = i_read && (i_addr == IUR_RX_TX_CHAR_PORT_ADDR);
  assign wr_data = i_write && (i_addr == IUR_RX_TX_CHAR_PORT_ADDR);
  assign rd_ctrl = i_read && (i_addr == IUR_IRQ_SETTINGS_ADDR);
  assign wr_ctrl = i_write && (i_addr == IUR_IRQ_SETTINGS_ADDR);
  assign fifo_pop = rd_data && (fifo_count != '0);

  iur_rx_fifo #(
    .DEPTH(DEPTH),
    .WIDTH(IUR_DATA_BITS)
  ) i_iur_rx_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_push(rx_push_reg),
    .i_data(rx_shift_reg),
    .i_pop(fifo_pop),
    .o_head(fifo_head),
    .o_count(fifo_count)
  );

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  logic tx_busy;
  logic tx_pin;
  iur_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) i_iur_tx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(wr_data && !tx_busy),
    .i_data(i_wdata[IUR_DATA_MSB:IUR_DATA_LSB]),
    .o_busy(tx_busy),
    .o_txd(tx_pin)
  );
  assign o_txd = tx_pin;

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic rx_irq_enable_reg;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_irq_enable_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      rx_irq_enable_reg <= i_wdata[IUR_RE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Read data path, one cycle after the read strobe
  // ------------------------------------------------------------
  logic [31:0] rdata_next;
  always_comb
  begin
    rdata_next = IUR_WORD_ZERO;
    if (rd_data)
    begin
      rdata_next[IUR_DATA_MSB:IUR_DATA_LSB] = fifo_head;
      rdata_next[IUR_VALID_BIT] = (fifo_count != '0);
      rdata_next[IUR_FILL_MSB:IUR_FILL_LSB] = 8'(fifo_count);
    end
    else if (rd_ctrl)
    begin
      rdata_next[IUR_RE_BIT] = rx_irq_enable_reg;
      rdata_next[IUR_RI_BIT] = rx_irq_enable_reg && (fifo_count != '0);
    end
  end

  // Read data register, zero unless a read was taken
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= IUR_WORD_ZERO;
    end
    else
    begin
      o_rdata <= rdata_next;
    end
  end

  // Read answer strobe, one cycle after every read at any address
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_read;
    end
  end
endmodule

// File: tb/iur_chk.sv
// Assertion checker for the infrared UART port
`timescale 1ns/1ps
module iur_chk
#(
  parameter int DEPTH = 4
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_addr,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_txd,
  input wire logic i_rxd
);
  import iur_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic dat;
  // Remembers whether the previous cycle's address hit the data register
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      dat <= 1'b0;
    else
      dat <= i_addr == IUR_RX_TX_CHAR_PORT_ADDR;
  AST_ANSWER: assert property (i_read |=> o_rvalid) else $error("read not answered");
  AST_QUIET: assert property (!i_read |=> !o_rvalid && o_rdata == 32'h0)
    else $error("stray read data");
  AST_TOP: assert property (o_rvalid |-> o_rdata[31:24] == 8'h00) else $error("upper byte set");
  AST_EMPTY: assert property (o_rvalid && dat && !o_rdata[15] |-> o_rdata[23:16] == 8'h00)
    else $error("count with no char");
  AST_VALID: assert property (o_rvalid && dat && o_rdata[15] |-> o_rdata[23:16] != 8'h00)
    else $error("valid with zero count");
  AST_BOUND: assert property (o_rvalid && dat |-> o_rdata[23:16] <= DEPTH)
    else $error("count above depth");
  AST_POP: assert property (o_rvalid && dat && o_rdata[15] ##2 o_rvalid && dat
    |-> o_rdata[23:16] <= $past(o_rdata[23:16], 2)) else $error("read did not pop");
  AST_RI: assert property (o_rvalid && !dat && !o_rdata[0] |-> !o_rdata[8])
    else $error("pending while disabled");
endmodule

bind iur_top iur_chk #(.DEPTH(DEPTH)) i_iur_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_read(i_read), .i_write(i_write), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_txd(o_txd), .i_rxd(i_rxd));

// File: tb/iur_ir_peer.sv
// Infrared transceiver model on the far side of the serial link
`timescale 1ns/1ps
module iur_ir_peer
#(
  parameter int BIT = 16
)
(
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  logic [7:0] got;
  logic stop_ok;
  int n_got = 0;
  initial o_rxd = 1'b1;
  // Sends start, eight data bits LSB first, one stop, no parity
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    @(posedge i_clk);
    for (int i = 0; i < 10; i++)
    begin
      o_rxd <= f[i];
      repeat (BIT) @(posedge i_clk);
    end
  endtask
  // Captures frames from the port at mid bit on the falling clock
  initial
  begin
    forever
    begin
      @(negedge i_txd);
      repeat (BIT / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(negedge i_clk);
        got[i] = i_txd;
      end
      repeat (BIT) @(negedge i_clk);
      stop_ok = i_txd;
      n_got++;
    end
  end
endmodule

// File: tb/tb_iur_top.sv
// Self-checking testbench for the infrared UART port
`timescale 1ns/1ps
module tb_iur_top;
  import iur_pkg::*;
  localparam int BIT = 16;
  localparam int DEPTH = 4;
  localparam logic [31:0] DAT = IUR_RX_TX_CHAR_PORT_ADDR;
  localparam logic [31:0] CTL = IUR_IRQ_SETTINGS_ADDR;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [31:0] i_addr = 32'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata;
  logic o_rvalid;
  logic o_txd;
  logic i_rxd;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] seed = 16'h000c;
  logic [7:0] c;
  logic [7:0] q[$];
  logic [31:0] d;
  iur_top #(.BIT_CYCLES(BIT), .DEPTH(DEPTH)) i_iur_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_read(i_read), .i_write(i_write), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_txd(o_txd), .i_rxd(i_rxd));
  iur_ir_peer #(.BIT(BIT)) i_iur_ir_peer (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));
  // Clock generation
  initial forever #2.5 i_clk = ~i_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected data word for a valid character
  function automatic logic [31:0] exp_data(input int n, input logic [7:0] ch);
    return {8'h00, n[7:0], 1'b1, 7'h00, ch};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_read <= 1'b0;
    #1;
    v = (o_rvalid === 1'b1) ? o_rdata : 32'hffffffff;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cuts a hung run short
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(CTL, d);
    check(d, 32'h0, "control reset");
    rd(DAT + 32'h8, d);
    check(d, 32'h0, "unmapped read");
    rd(DAT, d);
    check({23'h0, d[23:15]}, 32'h0, "empty read");
    $display("test reset done");
    for (int i = 0; i <= DEPTH; i++)
    begin
      seed = lfsr(seed);
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      if (i < DEPTH)
        q.push_back(c);
      i_iur_ir_peer.send(c);
      repeat (BIT) @(posedge i_clk);
    end
    rd(CTL, d);
    check(d, 32'h0, "pending while disabled");
    wr(CTL, 32'h1);
    rd(CTL, d);
    check(d, 32'h101, "pending with data");
    for (int n = DEPTH; n > 0; n--)
    begin
      rd(DAT, d);
      check(d, exp_data(n, q.pop_front()), "head char");
    end
    rd(DAT, d);
    check({23'h0, d[23:15]}, 32'h0, "drained read");
    rd(CTL, d);
    check(d, 32'h1, "pending cleared");
    $display("test receive done");
    seed = lfsr(seed);
    wr(DAT, {24'h0, seed[7:0]});
    wr(DAT, {24'h0, ~seed[7:0]});
    for (int k = 0; k < 12 * BIT && i_iur_ir_peer.n_got == 0; k++)
      @(posedge i_clk);
    check({24'h0, i_iur_ir_peer.got}, {24'h0, seed[7:0]}, "sent char");
    check({31'h0, i_iur_ir_peer.stop_ok}, 32'h1, "stop level");
    repeat (12 * BIT) @(posedge i_clk);
    check(i_iur_ir_peer.n_got, 32'h1, "busy write dropped");
    $display("test transmit done");
    report_and_stop();
  end
endmodule
